// File: logic/iea_pkg.sv
// Shared types and constants for the indirect effective address unit.
// Assumes a single 20 MHz clock and a synchronous byte-wide memory port.
package iea_pkg;
   // =========================================================================
   // Widths and timing
   localparam int unsigned IEA_CLK_MHZ   = 20;
   localparam int unsigned IEA_FULL_AW   = 16;
   localparam int unsigned IEA_AW_SMALL  = 12;
   localparam int unsigned IEA_AW_MID    = 13;
   localparam logic [7:0]  IEA_ZP_HIGH   = 8'h00;
   localparam logic [15:0] IEA_RST_ADDR  = 16'h0000;
   localparam logic [7:0]  IEA_RST_BYTE  = 8'h00;

   // =========================================================================
   // Modes and interrupt option sets
   typedef enum logic [1:0] {
      IEA_MODE_XIND,     // Pre-indexed through page zero with X
      IEA_MODE_INDY,     // Post-indexed through page zero with Y
      IEA_MODE_ABSIND,   // Absolute indirect jump
      IEA_MODE_NONE
   } iea_mode_e;

   typedef enum logic [1:0] {
      IEA_IRQ_BOTH,      // Maskable and non-maskable inputs present
      IEA_IRQ_MASK_ONLY, // Maskable request only
      IEA_IRQ_NONE       // No interrupt inputs
   } iea_irq_cfg_e;

   // Request from the core
   typedef struct packed {
      iea_mode_e  mode;
      logic [7:0] op_lo;   // Second instruction byte
      logic [7:0] op_hi;   // Third instruction byte
      logic [7:0] x_idx;
      logic [7:0] y_idx;
   } iea_req_s;

   // Memory read port
   typedef struct packed {
      logic        rd;
      logic [15:0] addr;
   } iea_mem_s;
endpackage : iea_pkg

// File: logic/iea_byte_add.sv
// Eight-bit adder with carry in and carry out, used for index sums.
// Purely combinational; the caller decides whether the carry is kept.
`timescale 1ns/1ns
module iea_byte_add (
   input  wire logic [7:0] a,     // First operand
   input  wire logic [7:0] b,     // Second operand
   input  wire logic       cin,   // Carry in
   output logic      [7:0] sum,   // Low eight bits
   output logic            cout   // Carry out
);
   // =========================================================================
   // Sum
   logic [8:0] full;
   assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
   assign sum  = full[7:0];
   assign cout = full[8];
endmodule : iea_byte_add

// File: logic/iea_unit.sv
// Effective address unit for the three indirect addressing modes.
// Assumes memory answers a read with data on MEM_DATA one cycle after
// MEM_RD, and that the core holds START for one cycle with REQ valid.
//
// Overview of operation
// RL1 - X-indexed pointer is byte sum, no carry
// RL2 - Pointer byte gives effective address low
// RL3 - Next page-zero byte gives high, wraps
// RL4 - Pointer byte plus Y gives low byte
// RL5 - Low carry added into fetched high byte
// RL6 - Pointer at last location wraps to zero
// RL7 - Two operand bytes form sixteen-bit pointer
// RL8 - Fetch target pair, load program counter
// RL9 - Address truncated to lines the variant has
// RL10 - Variant selects existing interrupt inputs
// RL11 - Page-zero fetches use zero high byte
`timescale 1ns/1ns
module iea_unit
   import iea_pkg::*;
#(
   parameter int unsigned ADDR_LINES = IEA_FULL_AW,   // 12, 13 or 16
   parameter iea_pkg::iea_irq_cfg_e IRQ_CFG = iea_pkg::IEA_IRQ_BOTH
) (
   input  wire logic                  CLOCK,     // 20 MHz system clock
   input  wire logic                  NRST,      // Async reset, active low
   input  wire logic                  START,     // One-cycle request strobe
   input  wire iea_pkg::iea_req_s     REQ,       // Mode, operands, indexes
   input  wire logic [7:0]            MEM_DATA,  // Read data, one cycle late
   input  wire logic                  IRQ_IN_N,  // Maskable request, low
   input  wire logic                  NMI_IN_N,  // Non-maskable request, low
   output logic                       MEM_RD,    // Memory read strobe
   output logic [ADDR_LINES-1:0]      ADDRESS_BUS_LINES, // Driven lines
   output logic                       BUSY,      // Sequence in progress
   output logic                       DONE,      // Result valid pulse
   output logic [15:0]                EFF_ADDR,  // Effective address
   output logic                       PC_LOAD,   // Jump target load pulse
   output logic [15:0]                PC,        // Program counter
   output logic                       IRQ_REQ,   // Gated maskable request
   output logic                       NMI_REQ    // Gated non-maskable req
);
   import iea_pkg::*;

   // =========================================================================
   // Elaboration checks
   // Only the three bus widths of the family are served
   if (!(ADDR_LINES == IEA_AW_SMALL || ADDR_LINES == IEA_AW_MID ||
         ADDR_LINES == IEA_FULL_AW)) begin : g_bad_aw
      $error("ADDR_LINES must be 12, 13 or 16");
   end

   // =========================================================================
   // Fetch sequence, one state per clock
   // IDLE : take START, latch mode and Y, issue the low pointer fetch
   // LO   : issue the high pointer fetch while memory answers the low one
   // HI   : low byte arrives; in post-indexed mode the Y sum and its carry are kept
   // LAST : high byte arrives; result, and for jumps the counter, load
   // The next request may be taken on the edge that ends DONE, so a
   // new sequence can start every four cycles at best.
   // Memory must answer in exactly one cycle; there is no wait input,
   // so slower memory needs a wrapper that stalls the core instead.
   // Both pointer fetches are issued back to back to keep the latency
   // fixed; the price is that memory sees two reads even for a jump.

   typedef enum logic [2:0] {
      ST_IDLE, ST_LO, ST_HI, ST_LAST, ST_DONE
   } iea_state_e;

   typedef struct packed {
      iea_state_e  st;
      iea_mode_e   mode;
      logic [15:0] ptr;
      logic [7:0]  y;
      logic [7:0]  lo;
      logic        carry;
      iea_mem_s    mem;
      logic        busy;
      logic        done;
      logic        pc_load;
      logic [15:0] eff;
      logic [15:0] pc;
      logic        irq;
      logic        nmi;
   } iea_state_s;

   // Registered state and the copy that the next-state logic fills
   iea_state_s s_r, s_nxt;

   // =========================================================================
   // Shared adders
   logic [7:0] xsum, ysum;
   logic       ycarry;
   logic [7:0] hsum;

   // Pointer plus X, carry discarded
   iea_byte_add u_xadd (
      .a    (REQ.op_lo),
      .b    (REQ.x_idx),
      .cin  (1'b0),
      .sum  (xsum),
      .cout ()
   );
   // Fetched low byte plus Y
   iea_byte_add u_yadd (
      .a    (MEM_DATA),
      .b    (s_r.y),
      .cin  (1'b0),
      .sum  (ysum),
      .cout (ycarry)
   );
   // Fetched high byte plus low carry
   iea_byte_add u_hadd (
      .a    (MEM_DATA),
      .b    (8'h00),
      .cin  (s_r.carry),
      .sum  (hsum),
      .cout ()            // Carry past sixteen bits is dropped
   );

   // =========================================================================
   // Next-state logic
   always_comb begin
      s_nxt         = s_r;
      s_nxt.mem.rd  = 1'b0;
      s_nxt.done    = 1'b0;
      s_nxt.pc_load = 1'b0;
      // Absent inputs read as never asserted
      // Levels only; catching an edge on the non-maskable input is the core's job
      s_nxt.irq = (IRQ_CFG != IEA_IRQ_NONE) && !IRQ_IN_N;              // RL10
      s_nxt.nmi = (IRQ_CFG == IEA_IRQ_BOTH) && !NMI_IN_N;              // RL10
      case (s_r.st)
         ST_IDLE: begin
            // An idle mode code is refused so a stray strobe costs nothing
            if (START && REQ.mode != IEA_MODE_NONE) begin
               s_nxt.mode  = REQ.mode;
               s_nxt.y     = REQ.y_idx;
               s_nxt.carry = 1'b0;
               s_nxt.busy  = 1'b1;
               case (REQ.mode)
                  IEA_MODE_XIND:   s_nxt.ptr = {IEA_ZP_HIGH, xsum};       // RL1 RL11
                  IEA_MODE_INDY:   s_nxt.ptr = {IEA_ZP_HIGH, REQ.op_lo};  // RL4 RL11
                  IEA_MODE_ABSIND: s_nxt.ptr = {REQ.op_hi, REQ.op_lo};    // RL7
                  default:         s_nxt.ptr = s_r.ptr;
               endcase
               s_nxt.mem.rd   = 1'b1;
               s_nxt.mem.addr = s_nxt.ptr;
               s_nxt.st       = ST_LO;
            end
         end
         ST_LO: begin
            // Issue the high fetch while memory answers the low one
            s_nxt.mem.rd = 1'b1;
            if (s_r.mode == IEA_MODE_ABSIND) begin
               s_nxt.mem.addr = s_r.ptr + 16'h0001;                       // RL8
            end else begin
               // Increment wraps inside page zero
               s_nxt.mem.addr = {IEA_ZP_HIGH, s_r.ptr[7:0] + 8'h01};      // RL3 RL6
            end
            s_nxt.st = ST_HI;
         end
         ST_HI: begin
            // Only the post-indexed mode adds Y; the others pass the byte
            if (s_r.mode == IEA_MODE_INDY) begin
               s_nxt.lo    = ysum;                                        // RL4
               s_nxt.carry = ycarry;                                      // RL5
            end else begin
               s_nxt.lo    = MEM_DATA;                                    // RL2 RL8
               s_nxt.carry = 1'b0;
            end
            s_nxt.st = ST_LAST;
         end
         ST_LAST: begin
            // All modes report the address; jumps also load the counter
            s_nxt.eff  = {hsum, s_r.lo};                                  // RL3 RL5
            s_nxt.done = 1'b1;
            s_nxt.busy = 1'b0;
            if (s_r.mode == IEA_MODE_ABSIND) begin
               s_nxt.pc      = {MEM_DATA, s_r.lo};                        // RL8
               s_nxt.pc_load = 1'b1;
            end
            s_nxt.st = ST_IDLE;
         end
         // Unused codes fall back to idle rather than lock up
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   // =========================================================================
   // State register
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         // Every field to a constant; nothing is sampled while in reset
         s_r <= '{st:      ST_IDLE,
                  mode:    IEA_MODE_NONE,
                  ptr:     IEA_RST_ADDR,
                  y:       IEA_RST_BYTE,
                  lo:      IEA_RST_BYTE,
                  carry:   1'b0,
                  mem:     '{rd: 1'b0, addr: IEA_RST_ADDR},
                  busy:    1'b0,
                  done:    1'b0,
                  pc_load: 1'b0,
                  eff:     IEA_RST_ADDR,
                  pc:      IEA_RST_ADDR,
                  irq:     1'b0,
                  nmi:     1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // =========================================================================
   // Outputs straight from the state register
   assign MEM_RD            = s_r.mem.rd;
   assign ADDRESS_BUS_LINES = s_r.mem.addr[ADDR_LINES-1:0];               // RL9
   // Busy has a flop of its own rather than a decode of the state,
   // so the core never sees a decode glitch on it
   assign BUSY              = s_r.busy;
   assign DONE              = s_r.done;
   assign PC_LOAD           = s_r.pc_load;
   // Upper bits beyond the present lines are never seen by memory
   assign EFF_ADDR          = s_r.eff;
   assign PC                = s_r.pc;
   assign IRQ_REQ           = s_r.irq;
   assign NMI_REQ           = s_r.nmi;
endmodule : iea_unit

// File: test/iea_unit_asserts.sv
// Port checker for the indirect effective address unit.
// Bound from tb_top; sees only the unit's own ports.
`timescale 1ns/1ns
module iea_unit_asserts
   import iea_pkg::*;
#(
   parameter int unsigned           ADDR_LINES = IEA_FULL_AW,
   parameter iea_pkg::iea_irq_cfg_e IRQ_CFG    = iea_pkg::IEA_IRQ_BOTH
) (
   input wire logic                  CLOCK,             // Clock
   input wire logic                  NRST,              // Reset
   input wire logic                  START,             // Strobe
   input wire iea_pkg::iea_req_s     REQ,               // Request
   input wire logic                  IRQ_IN_N,          // Maskable in
   input wire logic                  NMI_IN_N,          // Unmaskable in
   input wire logic                  MEM_RD,            // Read strobe
   input wire logic [ADDR_LINES-1:0] ADDRESS_BUS_LINES, // Address
   input wire logic                  BUSY,              // Busy
   input wire logic                  DONE,              // Result pulse
   input wire logic [15:0]           EFF_ADDR,          // Result
   input wire logic                  PC_LOAD,           // Jump pulse
   input wire logic [15:0]           PC,                // Counter
   input wire logic                  IRQ_REQ,           // Gated maskable
   input wire logic                  NMI_REQ            // Gated unmaskable
);
   // =====================================================================
   // Helpers: byte sums kept to eight bits by assignment, not by a cast
   logic       tk;
   logic [7:0] xp;
   logic [7:0] nx;
   assign tk = START && !BUSY && REQ.mode != IEA_MODE_NONE;
   assign xp = REQ.op_lo + REQ.x_idx;
   assign nx = ADDRESS_BUS_LINES[7:0] + 8'h01;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);
   // =====================================================================
   // Properties
   a_fetch_pair:
      assert property (tk |=> MEM_RD ##1 MEM_RD ##1 !MEM_RD) else $error("fetch pair wrong");
   a_xind_ptr:
      assert property (tk && REQ.mode == IEA_MODE_XIND |=>
         ADDRESS_BUS_LINES == ADDR_LINES'($past(xp))) else $error("pre-index pointer wrong");
   a_zp_next:
      assert property (tk && REQ.mode != IEA_MODE_ABSIND |=> ##1
         ADDRESS_BUS_LINES == ADDR_LINES'($past(nx))) else $error("page-zero wrap wrong");
   a_indy_ptr:
      assert property (tk && REQ.mode == IEA_MODE_INDY |=>
         ADDRESS_BUS_LINES == ADDR_LINES'($past(REQ.op_lo))) else $error("pointer wrong");
   a_abs_ptr:
      assert property (tk && REQ.mode == IEA_MODE_ABSIND |=>
         ADDRESS_BUS_LINES == ADDR_LINES'({$past(REQ.op_hi), $past(REQ.op_lo)}) ##1
         ADDRESS_BUS_LINES == $past(ADDRESS_BUS_LINES) + 1'b1) else $error("abs ptr wrong");
   a_result_time:
      assert property (tk |-> ##4 DONE && PC_LOAD == ($past(REQ.mode, 4) == IEA_MODE_ABSIND))
      else $error("result timing wrong");
   a_pc_value:
      assert property (PC_LOAD |-> DONE && PC == EFF_ADDR) else $error("counter not loaded");
   a_irq_gate:
      assert property (!IRQ_IN_N && !NMI_IN_N |=> IRQ_REQ == (IRQ_CFG != IEA_IRQ_NONE) &&
         NMI_REQ == (IRQ_CFG == IEA_IRQ_BOTH)) else $error("interrupt gating wrong");
endmodule : iea_unit_asserts

// File: test/iea_mem_model.sv
// Byte memory on the far side of the address unit.
// Answers one cycle after a read strobe, as the unit expects.
`timescale 1ns/1ns
module iea_mem_model #(
   parameter int unsigned AW = 16
) (
   input  wire logic          clock, // Clock
   input  wire logic          rd,    // Read strobe
   input  wire logic [AW-1:0] addr,  // Address lines
   output logic      [7:0]    data   // Read data
);
   logic [7:0] mem [0:(1<<AW)-1];
   // Idle bus inverts its data each cycle, so a stale byte shows only on every second idle cycle
   initial data = 8'h00;
   always @(posedge clock) begin
      if (rd) begin
         data <= mem[addr];
      end else begin
         data <= ~data;
      end
   end
endmodule : iea_mem_model

// File: test/tb_top.sv
// Self-checking bench for the indirect effective address unit.
// Runs a twelve-line, maskable-only variant against the memory model.
`timescale 1ns/1ns
module tb_top;
   import iea_pkg::*;
   localparam int unsigned AL = IEA_AW_SMALL;
   logic          clock, nrst, start, irq_in_n, nmi_in_n, mem_rd, busy, done;
   logic          pc_load, irq_req, nmi_req;
   iea_req_s      req;
   logic [7:0]    mem_data;
   logic [AL-1:0] abus;
   logic [15:0]   eff, pc;
   int            fails = 0, checked = 0;
   iea_unit #(.ADDR_LINES(AL), .IRQ_CFG(IEA_IRQ_MASK_ONLY)) u_dut (
      .CLOCK(clock), .NRST(nrst), .START(start), .REQ(req), .MEM_DATA(mem_data),
      .IRQ_IN_N(irq_in_n), .NMI_IN_N(nmi_in_n), .MEM_RD(mem_rd), .ADDRESS_BUS_LINES(abus),
      .BUSY(busy), .DONE(done), .EFF_ADDR(eff), .PC_LOAD(pc_load), .PC(pc),
      .IRQ_REQ(irq_req), .NMI_REQ(nmi_req));
   iea_mem_model #(.AW(AL)) u_mem (.clock(clock), .rd(mem_rd), .addr(abus), .data(mem_data));
   // =====================================================================
   // Shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         fails++;
      end
   endtask : chk
   // One request, then wait a bounded time for the result pulse
   task automatic go(input iea_mode_e m, input logic [7:0] lo, hi, x, y, input logic [15:0] e);
      int n;
      req = '{m, lo, hi, x, y};
      start = 1'b1;
      @(posedge clock);
      #1 start = 1'b0;
      for (n = 0; n < 8 && done !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      chk(16'(done), 16'h0001);
      chk(eff, e);
      chk(16'(pc_load), 16'(m == IEA_MODE_ABSIND));
      if (m == IEA_MODE_ABSIND) chk(pc, e);
   endtask : go
   task automatic s_xind;
      u_mem.mem[12'h010] = 8'h34;
      u_mem.mem[12'h011] = 8'h12;
      u_mem.mem[12'h0ff] = 8'hcd;
      u_mem.mem[12'h000] = 8'hab;
      go(IEA_MODE_XIND, 8'hf0, 8'h00, 8'h20, 8'h00, 16'h1234);
      go(IEA_MODE_XIND, 8'h80, 8'h00, 8'h7f, 8'h00, 16'habcd);
   endtask : s_xind
   task automatic s_indy;
      go(IEA_MODE_INDY, 8'hff, 8'h00, 8'h00, 8'h40, 16'hac0d);
      go(IEA_MODE_INDY, 8'h10, 8'h00, 8'h00, 8'h01, 16'h1235);
   endtask : s_indy
   task automatic s_abs;
      u_mem.mem[12'h2ff] = 8'h78;
      u_mem.mem[12'h300] = 8'h56;
      go(IEA_MODE_ABSIND, 8'hff, 8'hf2, 8'h11, 8'h22, 16'h5678);
   endtask : s_abs
   // A strobe while busy, and an idle mode, must both be ignored
   task automatic s_refuse;
      fork
         go(IEA_MODE_XIND, 8'hf0, 8'h00, 8'h20, 8'h00, 16'h1234);
         begin
            repeat (2) @(posedge clock);
            #1 start = 1'b1;
            req.op_lo = 8'h00;
            @(posedge clock);
            #1 start = 1'b0;
         end
      join
      req.mode = IEA_MODE_NONE;
      start = 1'b1;
      @(posedge clock);
      #1 start = 1'b0;
      @(posedge clock);
      #1 chk(16'(busy | mem_rd), 16'h0000);
   endtask : s_refuse
   task automatic s_irq;
      irq_in_n = 1'b0;
      nmi_in_n = 1'b0;
      @(posedge clock);
      #1 chk(16'({irq_req, nmi_req}), 16'h0002);
      irq_in_n = 1'b1;
      nmi_in_n = 1'b1;
      @(posedge clock);
      #1 chk(16'(irq_req), 16'h0000);
   endtask : s_irq
   task automatic print_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   // =====================================================================
   // Clock, main sequence and watchdog
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      {nrst, start, req} = '0;
      {irq_in_n, nmi_in_n} = 2'b11;
      repeat (8) @(posedge clock);
      #1 nrst = 1'b1;
      s_xind;
      s_indy;
      s_abs;
      s_refuse;
      s_irq;
      print_verdict;
   end
   // Tests need under 60 cycles; allow far more before giving up
   initial begin
      #20000;
      fails++;
      print_verdict;
   end
endmodule : tb_top
bind iea_unit iea_unit_asserts #(.ADDR_LINES(ADDR_LINES), .IRQ_CFG(IRQ_CFG)) u_chk (
   .CLOCK(CLOCK), .NRST(NRST), .START(START), .REQ(REQ), .IRQ_IN_N(IRQ_IN_N),
   .NMI_IN_N(NMI_IN_N), .MEM_RD(MEM_RD), .ADDRESS_BUS_LINES(ADDRESS_BUS_LINES), .BUSY(BUSY),
   .DONE(DONE), .EFF_ADDR(EFF_ADDR), .PC_LOAD(PC_LOAD), .PC(PC), .IRQ_REQ(IRQ_REQ),
   .NMI_REQ(NMI_REQ));
